// ---- bench/cmu_compare_unit_props.sv ----
// port-level checks on the compare unit, bound to its top module
`timescale 1ns/10ps
module cmu_compare_unit_props (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic timer_a_inc,
    input wire logic timer_a_wr,
    input wire logic timer_b_inc,
    input wire logic timer_b_wr,
    input wire logic [15:0] compare_out_pin,
    input wire logic [15:0] pin_oe_n,
    input wire logic [15:0] cmp_irq_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic step_any;
    logic stepped;
    // any timer step or software load re-arms channels
    assign step_any = timer_a_inc | timer_a_wr | timer_b_inc | timer_b_wr;
    // remembers whether a timer has moved since reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stepped <= 1'b0;
        end else if (step_any) begin
            stepped <= 1'b1;
        end
    end
    aw_w_pair_a: assert property (s_axi_awready |-> s_axi_wready)
        else $error("write address and data not taken together");
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write ready longer than one cycle");
    wr_answer_a: assert property (s_axi_awready && s_axi_awvalid && s_axi_wvalid |=> s_axi_bvalid)
        else $error("no write response after write taken");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
        else $error("read answer missing or upper half set");
    no_early_a: assert property (!stepped |-> cmp_irq_flag == 16'h0000)
        else $error("request flag before any timer step");
    flag_cause_a: assert property ((cmp_irq_flag & ~$past(cmp_irq_flag)) != 16'h0000 |-> $past(step_any) || $past(s_axi_awready, 2))
        else $error("request flag set without a cause");
    pin_cause_a: assert property (compare_out_pin != $past(compare_out_pin) |-> $past(step_any) || $past(s_axi_awready) || $past(s_axi_awready, 2))
        else $error("output latch moved without a cause");
    oe_cause_a: assert property (pin_oe_n != $past(pin_oe_n) |-> $past(s_axi_awready))
        else $error("pin direction moved without a bus write");
endmodule : cmu_compare_unit_props

bind cmu_compare_unit cmu_compare_unit_props u_props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .timer_a_inc(timer_a_inc), .timer_a_wr(timer_a_wr), .timer_b_inc(timer_b_inc), .timer_b_wr(timer_b_wr),
    .compare_out_pin(compare_out_pin), .pin_oe_n(pin_oe_n), .cmp_irq_flag(cmp_irq_flag)
);

// ---- bench/cmu_compare_unit_tb.sv ----
// register-bus and timer-link bench for the compare unit
`timescale 1ns/10ps
module cmu_compare_unit_tb;
    localparam logic [1:0] OK = cmu_pkg::RESP_OKAY;
    localparam logic [5:0] CV = cmu_pkg::IDX_CV_BASE;
    localparam logic [5:0] MB = cmu_pkg::IDX_MODE_BASE;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic st_a = 1'b0, st_b = 1'b0, ld_a = 1'b0, ld_b = 1'b0;
    logic [15:0] ld_val = 16'h0000, pin_drv = 16'h0000;
    logic [15:0] cnt_a, cnt_b, pins, oe_n, flags;
    logic inc_a, ovf_a, wr_a, inc_b, ovf_b, wr_b;
    int fail_count = 0;
    int check_count = 0;
    // ************************************************************
    // clock, partner timers and the unit
    // ************************************************************
    always #5 sys_clk = ~sys_clk;
    cmu_timer_model tm_a (.sys_clk(sys_clk), .sys_rst(sys_rst), .step(st_a), .load(ld_a), .load_val(ld_val),
        .count(cnt_a), .inc(inc_a), .ovf(ovf_a), .wr(wr_a));
    cmu_timer_model tm_b (.sys_clk(sys_clk), .sys_rst(sys_rst), .step(st_b), .load(ld_b), .load_val(ld_val),
        .count(cnt_b), .inc(inc_b), .ovf(ovf_b), .wr(wr_b));
    cmu_compare_unit uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_a_count(cnt_a),
        .timer_a_inc(inc_a), .timer_a_ovf(ovf_a), .timer_a_wr(wr_a), .timer_b_count(cnt_b),
        .timer_b_inc(inc_b), .timer_b_ovf(ovf_b), .timer_b_wr(wr_b), .pin_in(pin_drv),
        .compare_out_pin(pins), .pin_oe_n(oe_n), .cmp_irq_flag(flags));
    // ************************************************************
    // bus, timer and compare tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // address and data are offered together and held until taken
    task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er = OK);
        @(posedge sys_clk);
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do @(posedge sys_clk); while (awready !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : wr
    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er = OK);
        @(posedge sys_clk);
        araddr <= {idx, 2'b00};
        arv <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arv <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        chk("rdata", exp, rdata);
    endtask : rdc
    // steps one timer n times, two cycles apart, then lets the outputs settle
    task automatic tstep(input logic sel, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            st_a <= !sel;
            st_b <= sel;
            @(posedge sys_clk);
            st_a <= 1'b0;
            st_b <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
    endtask : tstep
    task automatic tload(input logic sel, input logic [15:0] v);
        @(posedge sys_clk);
        ld_a <= !sel;
        ld_b <= sel;
        ld_val <= v;
        @(posedge sys_clk);
        ld_a <= 1'b0;
        ld_b <= 1'b0;
    endtask : tload
    task automatic outs(input logic [15:0] p, input logic [15:0] f);
        chk("pins", {16'h0000, p}, {16'h0000, pins});
        chk("flags", {16'h0000, f}, {16'h0000, flags});
    endtask : outs
    task automatic results;
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [15:0] mw;
        // ch0 mode1/a, ch1 mode0/a, ch2 mode2/b, ch3 mode3/a
        mw = {1'b0, cmu_pkg::MODE_CMP3, 1'b1, cmu_pkg::MODE_CMP2, 1'b0, cmu_pkg::MODE_CMP0, 1'b0, cmu_pkg::MODE_CMP1};
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        chk("oe", {16'h0000, cmu_pkg::DIR_RST ^ 16'hFFFF}, {16'h0000, oe_n});
        rdc(MB, 32'h0);
        rdc(6'h18, 32'h0, cmu_pkg::RESP_SLVERR);
        wr(6'h3F, 16'hFFFF, cmu_pkg::RESP_SLVERR);
        wr(CV, 16'h000A);
        wr(CV + 6'h08, 16'h000A);
        wr(CV + 6'h01, 16'h000A);
        wr(CV + 6'h02, 16'h000A);
        wr(CV + 6'h03, 16'h000C);
        wr(MB, mw);
        wr(MB + 6'h02, 16'h0044); // ch8 mode0 pairs with ch0, ch9 stays alone
        wr(cmu_pkg::IDX_DIR, 16'h000F);
        chk("oe", 32'h0000FFF0, {16'h0000, oe_n});
        pin_drv <= 16'hFFFF;
        rdc(MB, {16'h0000, mw});
        rdc(cmu_pkg::IDX_PIN, 32'h0000FFFF);
        wr(cmu_pkg::IDX_PIN, 16'h0000);
        outs(16'h0000, 16'h0000); // ch9 equals count 0 but no step yet
        tload(1'b0, 16'h0008);
        tstep(1'b0, 2);
        outs(16'h0001, 16'h0103);
        wr(cmu_pkg::IDX_FLAG, 16'h0103);
        outs(16'h0001, 16'h0000);
        wr(CV + 6'h01, 16'h000B);
        wr(CV + 6'h09, 16'h000B);
        tstep(1'b0, 1);
        outs(16'h0001, 16'h0202);
        tstep(1'b0, 1);
        outs(16'h0009, 16'h020A);
        wr(CV + 6'h03, 16'h000D);
        tstep(1'b0, 1);
        outs(16'h0009, 16'h020A);
        wr(cmu_pkg::IDX_LATCH, 16'h0008);
        wr(CV, 16'h000E);
        tstep(1'b0, 1);
        outs(16'h0009, 16'h020B); // pins read high, latch bit was low
        wr(CV, 16'h000F);
        fork
            wr(cmu_pkg::IDX_LATCH, 16'h0009);
            tstep(1'b0, 1);
        join
        outs(16'h0009, 16'h020B);
        wr(cmu_pkg::IDX_FLAG, 16'hFFFF);
        tload(1'b1, 16'h0009);
        tstep(1'b1, 1);
        outs(16'h0009, 16'h0004);
        wr(cmu_pkg::IDX_FLAG, 16'h0004);
        wr(CV + 6'h02, 16'h000B);
        tstep(1'b1, 1);
        outs(16'h0009, 16'h0000);
        tload(1'b0, 16'hFFFF);
        tstep(1'b0, 1);
        outs(16'h0001, 16'h0000);
        tstep(1'b0, 13);
        outs(16'h0008, 16'h030A);
        results();
    end
    // cuts a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        results();
    end
endmodule : cmu_compare_unit_tb

// ---- bench/cmu_timer_model.sv ----
// timer model that feeds count and step strobes to the compare unit
`timescale 1ns/10ps
module cmu_timer_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic step,
    input wire logic load,
    input wire logic [15:0] load_val,
    output logic [15:0] count,
    output logic inc,
    output logic ovf,
    output logic wr
);
    // strobes stand for the first cycle of a new count only; overflow rides with the increment
    always_ff @(posedge sys_clk) begin
        inc <= 1'b0;
        ovf <= 1'b0;
        wr <= 1'b0;
        if (sys_rst) begin
            count <= 16'h0000;
        end else if (load) begin
            count <= load_val;
            wr <= 1'b1;
        end else if (step) begin
            count <= count + 16'h0001;
            inc <= 1'b1;
            ovf <= (count == 16'hFFFF);
        end
    end
endmodule : cmu_timer_model

// ---- rtl/cmu_compare_unit.sv ----
// sixteen channel compare unit with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps

// Notes on behaviour
// R1: each compare value matched against its timer
// R2: equal values all fire within eight states
// R3: one event per value until timer steps
// R4: no event before timer step and mode
// R5: mode 0 sets flag, pin untouched
// R6: mode 0 fires again after value change
// R7: bank-2 mode 0 pairs with mode-1 partner
// R8: mode 1 sets flag and toggles pin
// R9: toggle inverts the latch, not pin
// R10: mode 1 ignores timer overflow
// R11: software latch write beats hardware change
// R12: software sets direction output before use
// R13: mode 2 flags only first match
// R14: mode 2 blocked until timer overflow
// R15: mode 3 first match sets latch
// R16: mode 3 clears latch on overflow
// R17: mode 3 blocked until overflow, reload later
// R18: channels split into two banks of eight
// R19: pair n, n+8 drive pin n
// R20: select bit picks timer a or b
// R21: unpaired bank-2 mode 0 is interrupt only
// R22: paired match sets own flag, toggles pin
// R23: simultaneous pair match toggles once
// R24: timers supply count and one-cycle strobes
module cmu_compare_unit (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] timer_a_count,
    input wire logic timer_a_inc,
    input wire logic timer_a_ovf,
    input wire logic timer_a_wr,
    input wire logic [15:0] timer_b_count,
    input wire logic timer_b_inc,
    input wire logic timer_b_ovf,
    input wire logic timer_b_wr,
    input wire logic [15:0] pin_in,
    output logic [15:0] compare_out_pin,
    output logic [15:0] pin_oe_n,
    output logic [15:0] cmp_irq_flag
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [15:0] compare_value_reg [0:cmu_pkg::NUM_CH-1];
    logic [15:0] mode_ctl [0:cmu_pkg::NUM_CTL-1];
    logic [15:0] port_latch_bit;
    logic [15:0] pin_sync1;
    logic [15:0] pin_sync2;
    logic [15:0] cmp_event;     // one-cycle compare event per channel
    logic [15:0] armed;         // value may fire again after a timer step
    logic [15:0] period_lock;   // modes 2 and 3: fired in this period
    logic [2:0] ch_mode [0:cmu_pkg::NUM_CH-1];

    // bus side decode
    logic wr_fire;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic [31:0] next_rdata;
    logic rd_ok;
    logic wr_ok;

    // merge the two low byte lanes of a write into a 16-bit register
    function automatic logic [15:0] cmu_merge(input logic [15:0] old_val, input logic [31:0] wd,
                                              input logic [3:0] strb);
        logic [15:0] res;
        res = old_val;
        if (strb[0]) begin
            res[cmu_pkg::LANE_W-1:0] = wd[cmu_pkg::LANE_W-1:0];
        end
        if (strb[1]) begin
            res[2*cmu_pkg::LANE_W-1:cmu_pkg::LANE_W] = wd[2*cmu_pkg::LANE_W-1:cmu_pkg::LANE_W];
        end
        return res;
    endfunction : cmu_merge

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    // address and data are taken together in one cycle; both stay held by the master until then
    assign wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
    assign wr_idx = s_axi_awaddr[cmu_pkg::ADDR_W-1:cmu_pkg::IDX_LSB];
    assign wr_ok = (wr_idx <= cmu_pkg::IDX_PIN);

    // ready pulses for one cycle once both halves are offered and no answer is pending
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
        end
    end

    // write response; unmapped words answer with a slave error and change nothing
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cmu_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? cmu_pkg::RESP_OKAY : cmu_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    assign rd_idx = s_axi_araddr[cmu_pkg::ADDR_W-1:cmu_pkg::IDX_LSB];

    // read data mux; the upper half of each word reads as zero
    always_comb begin
        next_rdata = '0;
        rd_ok = 1'b1;
        if (rd_idx < cmu_pkg::IDX_MODE_BASE) begin
            next_rdata = {cmu_pkg::READ_PAD, compare_value_reg[rd_idx[3:0]]};
        end else if (rd_idx < cmu_pkg::IDX_FLAG) begin
            next_rdata = {cmu_pkg::READ_PAD, mode_ctl[rd_idx[1:0]]};
        end else if (rd_idx == cmu_pkg::IDX_FLAG) begin
            next_rdata = {cmu_pkg::READ_PAD, cmp_irq_flag};
        end else if (rd_idx == cmu_pkg::IDX_LATCH) begin
            next_rdata = {cmu_pkg::READ_PAD, port_latch_bit};
        end else if (rd_idx == cmu_pkg::IDX_DIR) begin
            next_rdata = {cmu_pkg::READ_PAD, ~pin_oe_n};
        end else if (rd_idx == cmu_pkg::IDX_PIN) begin
            next_rdata = {cmu_pkg::READ_PAD, pin_sync2};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // address taken one cycle after arvalid; data follows on the same edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
        end
    end

    // read response held until the master takes it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= cmu_pkg::RESP_OKAY;
        end else if (s_axi_arready & s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_ok ? cmu_pkg::RESP_OKAY : cmu_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // mode control words
    // ************************************************************
    for (genvar c = 0; c < cmu_pkg::NUM_CTL; c++) begin : g_ctl
        localparam logic [5:0] MY_IDX = 6'(cmu_pkg::IDX_MODE_BASE + c);

        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                mode_ctl[c] <= cmu_pkg::MODE_RST;
            end else if (wr_fire && wr_idx == MY_IDX) begin
                mode_ctl[c] <= cmu_merge(mode_ctl[c], s_axi_wdata, s_axi_wstrb);
            end
        end
    end

    // ************************************************************
    // pin level synchroniser (read back only)
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_sync1 <= '0;
            pin_sync2 <= '0;
        end else begin
            pin_sync1 <= pin_in;
            pin_sync2 <= pin_sync1;
        end
    end

    // ************************************************************
    // per channel compare and pin logic
    // ************************************************************
    for (genvar i = 0; i < cmu_pkg::NUM_CH; i++) begin : g_ch
        localparam int CTL = i / cmu_pkg::CH_PER_CTL;
        localparam int FLD = (i % cmu_pkg::CH_PER_CTL) * cmu_pkg::FIELD_W;
        localparam int LANE = i / cmu_pkg::LANE_W;
        localparam logic [5:0] MY_IDX = 6'(cmu_pkg::IDX_CV_BASE + i);

        logic tsel;
        logic [15:0] cnt;
        logic step;
        logic ovf;
        logic is_cmp;
        logic hit;
        logic once_mode;
        logic toggle_req;
        logic sw_latch;

        assign ch_mode[i] = mode_ctl[CTL][FLD + cmu_pkg::MODE_LSB +: cmu_pkg::MODE_W];
        assign tsel = mode_ctl[CTL][FLD + cmu_pkg::TSEL_BIT];

        // timer allocation: 0 picks timer a, 1 picks timer b [R20] [R24]
        assign cnt = tsel ? timer_b_count : timer_a_count;
        assign step = tsel ? (timer_b_inc | timer_b_wr) : (timer_a_inc | timer_a_wr);
        assign ovf = tsel ? timer_b_ovf : timer_a_ovf;

        assign is_cmp = (ch_mode[i] == cmu_pkg::MODE_CMP0) || (ch_mode[i] == cmu_pkg::MODE_CMP1) ||
                        (ch_mode[i] == cmu_pkg::MODE_CMP2) || (ch_mode[i] == cmu_pkg::MODE_CMP3);
        assign once_mode = (ch_mode[i] == cmu_pkg::MODE_CMP2) || (ch_mode[i] == cmu_pkg::MODE_CMP3);

        // all channels compare in parallel, so equal values fire in the same cycle [R1] [R2]
        // a step re-arms, and an overflow unlocks, in the very cycle the new count appears [R3] [R4]
        assign hit = is_cmp & (cnt == compare_value_reg[i]) & (armed[i] | step) & (~period_lock[i] | ovf);
        assign cmp_event[i] = hit;

        // compare value storage; a new value can fire once the timer steps onto it [R6]
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                compare_value_reg[i] <= cmu_pkg::CV_RST;
            end else if (wr_fire && wr_idx == MY_IDX) begin
                compare_value_reg[i] <= cmu_merge(compare_value_reg[i], s_axi_wdata, s_axi_wstrb);
            end
        end

        // arm flag: cleared at reset and by an event, set by a timer step [R3] [R4]
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                armed[i] <= 1'b0;
            end else if (hit) begin
                armed[i] <= 1'b0;   // [R3]
            end else if (step) begin
                armed[i] <= 1'b1;
            end
        end

        // once-per-period lock; held clear outside modes 2 and 3, so overflow does nothing in mode 1 [R10]
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                period_lock[i] <= 1'b0;
            end else if (hit && once_mode) begin
                period_lock[i] <= 1'b1;   // [R13] [R14] [R17]
            end else if (ovf || !once_mode) begin
                period_lock[i] <= 1'b0;   // a value reloaded after the match only counts next period [R14] [R17]
            end
        end

        // request flag: hardware set wins over a software clear in the same cycle [R1] [R22] [R23]
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                cmp_irq_flag[i] <= 1'b0;
            end else if (hit) begin
                cmp_irq_flag[i] <= 1'b1;   // [R5] [R8] [R13] [R15]
            end else if (wr_fire && wr_idx == cmu_pkg::IDX_FLAG && s_axi_wstrb[LANE] && s_axi_wdata[i]) begin
                cmp_irq_flag[i] <= 1'b0;
            end
        end

        // toggle source: own mode-1 match, or a paired bank-2 partner match [R18] [R19]
        if (i < cmu_pkg::BANK_SIZE) begin : g_bank1
            logic paired;
            // partner in mode 0 pairs only while this channel is in mode 1 [R7] [R21]
            assign paired = (ch_mode[i] == cmu_pkg::MODE_CMP1) &&
                            (ch_mode[i + cmu_pkg::BANK_SIZE] == cmu_pkg::MODE_CMP0);
            // or-ing both members means a double match toggles once [R22] [R23]
            assign toggle_req = (hit && ch_mode[i] == cmu_pkg::MODE_CMP1) ||
                                (paired && cmp_event[i + cmu_pkg::BANK_SIZE]);
        end else begin : g_bank2
            // a bank-2 channel in mode 0 never drives its own pin [R5] [R21]
            assign toggle_req = hit && ch_mode[i] == cmu_pkg::MODE_CMP1;   // [R8]
        end

        assign sw_latch = wr_fire && wr_idx == cmu_pkg::IDX_LATCH && s_axi_wstrb[LANE];

        // port latch: software write first, then set, overflow clear, toggle
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                port_latch_bit[i] <= cmu_pkg::LATCH_RST[i];
            end else if (sw_latch) begin
                port_latch_bit[i] <= s_axi_wdata[i];   // hardware change discarded [R11]
            end else if (hit && ch_mode[i] == cmu_pkg::MODE_CMP3) begin
                port_latch_bit[i] <= 1'b1;   // first match of the period [R15]
            end else if (ovf && ch_mode[i] == cmu_pkg::MODE_CMP3) begin
                port_latch_bit[i] <= 1'b0;   // [R16]
            end else if (toggle_req) begin
                port_latch_bit[i] <= ~port_latch_bit[i];   // reads the latch, never the pin [R9]
            end
        end

        // direction: software sets pin_oe_n low to make a pin an output; compare_out_pin carries the latch either way [R12]
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                pin_oe_n[i] <= ~cmu_pkg::DIR_RST[i];
            end else if (wr_fire && wr_idx == cmu_pkg::IDX_DIR && s_axi_wstrb[LANE]) begin
                pin_oe_n[i] <= ~s_axi_wdata[i];
            end
        end
    end

    // latch drives the pin output directly
    assign compare_out_pin = port_latch_bit;

endmodule : cmu_compare_unit

// ---- rtl/cmu_pkg.sv ----
// shared constants for the compare unit: channel counts, mode codes, register map
package cmu_pkg;

    // ************************************************************
    // channel organisation
    // ************************************************************
    localparam int NUM_CH = 16;          // compare channels
    localparam int BANK_SIZE = 8;        // channels per bank for pairing
    localparam int CV_W = 16;            // compare value and timer width
    localparam int CH_PER_CTL = 4;       // channels held by one mode control word
    localparam int NUM_CTL = 4;          // mode control words
    localparam int FIELD_W = 4;          // bits per channel in a mode control word
    localparam int MODE_LSB = 0;         // mode field position inside a channel field
    localparam int MODE_W = 3;           // mode field width
    localparam int TSEL_BIT = 3;         // timer select position inside a channel field
    localparam int LANE_W = 8;           // bits per byte lane

    // ************************************************************
    // compare mode encodings (other codes leave the channel idle)
    // ************************************************************
    localparam logic [2:0] MODE_CMP0 = 3'h4;  // interrupt only, many per period
    localparam logic [2:0] MODE_CMP1 = 3'h5;  // toggle latch on each match
    localparam logic [2:0] MODE_CMP2 = 3'h6;  // interrupt only, once per period
    localparam logic [2:0] MODE_CMP3 = 3'h7;  // set latch on match, clear on overflow

    // ************************************************************
    // register map: word index, byte address is four times the index
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int IDX_W = 6;
    localparam int IDX_LSB = 2;
    localparam logic [5:0] IDX_CV_BASE = 6'h00;    // sixteen compare values
    localparam logic [5:0] IDX_MODE_BASE = 6'h10;  // four mode control words
    localparam logic [5:0] IDX_FLAG = 6'h14;       // request flags, write one to clear
    localparam logic [5:0] IDX_LATCH = 6'h15;      // port output latch
    localparam logic [5:0] IDX_DIR = 6'h16;        // pin direction, 1 = output
    localparam logic [5:0] IDX_PIN = 6'h17;        // synchronised pin levels, read only

    // ************************************************************
    // reset values and bus answers
    // ************************************************************
    localparam logic [15:0] CV_RST = 16'h0000;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] LATCH_RST = 16'h0000;
    localparam logic [15:0] DIR_RST = 16'h0000;    // all pins input after reset
    localparam logic [15:0] READ_PAD = 16'h0000;   // upper half of every read word
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cmu_pkg
